/* include/bdec_pkg.sv */
// constants and carrier types for the bridge discard error control block
package bdec_pkg;

   // configuration offset and reset value of the bridge extension control register
   localparam logic [7:0] BDEC_BRCTL_OFS = 8'h3E;
   localparam logic [15:0] BDEC_BRCTL_RST = 16'h0000;

   // field positions inside the register
   localparam int BDEC_RSVD_MSB = 15;
   localparam int BDEC_RSVD_LSB = 12;
   localparam int BDEC_MSGEN_BIT = 11;
   localparam int BDEC_FLAG_BIT = 10;
   localparam int BDEC_TSEL_BIT = 9;

   // byte lane that carries bits 15:8
   localparam int BDEC_UPPER_LANE = 1;

   // discard timer lengths, in PCI clocks (one PCI clock per rising CLOCK edge)
   localparam int BDEC_DT_LONG_CLKS = 32768;
   localparam int BDEC_DT_SHORT_CLKS = 1024;
   localparam int BDEC_DT_CNT_W = 16;

   // one configuration access, taken in a single cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } bdec_cfg_t;

   // error message request towards the primary link
   typedef struct packed {
      logic valid;
      logic fatal;
   } bdec_msg_t;

   typedef enum logic [0:0] {
      BDEC_TMR_IDLE = 1'b0,
      BDEC_TMR_RUN = 1'b1
   } bdec_tmr_state_t;

endpackage

/* rtl/bdec_discard_timer.sv */
// secondary discard timer: counts after the delayed completion reaches the head
`timescale 1ns/1ps
module bdec_discard_timer
   import bdec_pkg::*;
#(
   parameter int LONG_CLKS = BDEC_DT_LONG_CLKS,
   parameter int SHORT_CLKS = BDEC_DT_SHORT_CLKS
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic retry,
   input wire logic sel_short,
   output logic busy,
   output logic expire
);
   bdec_tmr_state_t state_r, state_nxt;
   logic [BDEC_DT_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [BDEC_DT_CNT_W-1:0] len_r, len_nxt;
   logic expire_r, expire_nxt;
   logic [BDEC_DT_CNT_W:0] run_len_r;

   // next state; the length is latched at start so a later select change cannot stretch a run
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      len_nxt = len_r;
      expire_nxt = 1'b0;
      case (state_r)
         BDEC_TMR_IDLE:
         begin
            if (start)
            begin
               len_nxt = sel_short ? BDEC_DT_CNT_W'(SHORT_CLKS - 1) : BDEC_DT_CNT_W'(LONG_CLKS - 1);
               cnt_nxt = len_nxt;
               state_nxt = BDEC_TMR_RUN;
            end
         end
         BDEC_TMR_RUN:
         begin
            if (retry)
            begin
               state_nxt = BDEC_TMR_IDLE; // master came back in time
            end
            else if (cnt_r == '0)
            begin
               expire_nxt = 1'b1;
               state_nxt = BDEC_TMR_IDLE;
            end
            else
            begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default:
         begin
            state_nxt = BDEC_TMR_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r <= BDEC_TMR_IDLE;
         cnt_r <= '0;
         len_r <= '0;
         expire_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         len_r <= len_nxt;
         expire_r <= expire_nxt;
      end
   end

   assign busy = (state_r == BDEC_TMR_RUN);
   assign expire = expire_r;

   // helper: cycles since the run began, only read by the check below
   always_ff @(posedge clk)
   begin
      if (srst || state_r == BDEC_TMR_IDLE)
      begin
         run_len_r <= '0;
      end
      else
      begin
         run_len_r <= run_len_r + 1'b1;
      end
   end

   a_timer_length:
   assert property (@(posedge clk) disable iff (srst)
      expire_r |-> (run_len_r == {1'b0, len_r} + 1'b1))
   else $error("discard timer expired after wrong number of clocks");

   a_retry_cancels:
   assert property (@(posedge clk) disable iff (srst)
      (state_r == BDEC_TMR_RUN && retry) |=> !expire_r ##1 !expire_r)
   else $error("discard timer expired after master retried");

endmodule // bdec_discard_timer

/* rtl/bdec_top.sv */
// bridge extension control register upper bits and discard error reporting
`timescale 1ns/1ps

// Function
// - register at 3Eh, resets to all zero
// - bits 15:12 read zero, ignore writes
// - message enable honoured only in conventional mode
// - enabled: send error message per discard
// - nonfatal default; fatal only with advanced reporting
// - disabled suppresses, unless advanced unmasked path
// - status flag set per discard, cleared by software
// - timer runs 2^15 or 2^10 clocks
// - no retry before expiry drops transaction, flags
module bdec_top
   import bdec_pkg::*;
#(
   parameter int DT_LONG_CLKS = BDEC_DT_LONG_CLKS,
   parameter int DT_SHORT_CLKS = BDEC_DT_SHORT_CLKS,
   parameter bit AER_SUPPORTED = 1'b1
)
(
   input wire logic CLOCK,
   input wire logic SRST,
   input bdec_pkg::bdec_cfg_t CFG_REQ,
   output logic [15:0] CFG_RDATA,
   output logic CFG_RVALID,
   input wire logic CONV_PCI_MODE,
   input wire logic DC_AT_HEAD,
   input wire logic MASTER_RETRY,
   input wire logic AER_DT_MASK,
   input wire logic AER_DT_FATAL,
   output logic DT_DROP,
   output logic DT_BUSY,
   output bdec_pkg::bdec_msg_t ERR_MSG,
   input wire logic ERR_MSG_READY
);
   import bdec_pkg::*;

   logic discard_error_msg_enable_r, discard_error_msg_enable_nxt;
   logic discard_expiry_flag_r, discard_expiry_flag_nxt;
   logic secondary_timeout_select_r, secondary_timeout_select_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic msg_pend_r, msg_pend_nxt;
   logic msg_fatal_r, msg_fatal_nxt;
   logic hit;
   logic wr_upper;
   logic dt_expire;
   logic en_path;
   logic aer_path;
   logic send_msg;
   logic [15:0] reg_view;

   // discard timer; the drop strobe goes straight to the queue logic
   bdec_discard_timer #(
      .LONG_CLKS(DT_LONG_CLKS),
      .SHORT_CLKS(DT_SHORT_CLKS)
   ) u_timer (
      .clk(CLOCK),
      .srst(SRST),
      .start(DC_AT_HEAD),
      .retry(MASTER_RETRY),
      .sel_short(secondary_timeout_select_r),
      .busy(DT_BUSY),
      .expire(dt_expire)
   );

   // decode and the two paths that may raise a message
   assign hit = (CFG_REQ.addr == BDEC_BRCTL_OFS);
   assign wr_upper = CFG_REQ.wr && hit && CFG_REQ.be[BDEC_UPPER_LANE];
   assign en_path = CONV_PCI_MODE && discard_error_msg_enable_r;
   assign aer_path = AER_SUPPORTED && !AER_DT_MASK;
   assign send_msg = dt_expire && (en_path || aer_path);

   // register as software sees it; lower control bits live elsewhere and read zero here
   always_comb
   begin
      reg_view = BDEC_BRCTL_RST;
      reg_view[BDEC_RSVD_MSB:BDEC_RSVD_LSB] = 4'h0;
      reg_view[BDEC_MSGEN_BIT] = discard_error_msg_enable_r;
      reg_view[BDEC_FLAG_BIT] = discard_expiry_flag_r;
      reg_view[BDEC_TSEL_BIT] = secondary_timeout_select_r;
   end

   // next values of the register bits
   always_comb
   begin
      discard_error_msg_enable_nxt = discard_error_msg_enable_r;
      secondary_timeout_select_nxt = secondary_timeout_select_r;
      discard_expiry_flag_nxt = discard_expiry_flag_r;
      if (wr_upper)
      begin
         discard_error_msg_enable_nxt = CFG_REQ.wdata[BDEC_MSGEN_BIT];
         secondary_timeout_select_nxt = CFG_REQ.wdata[BDEC_TSEL_BIT];
         if (CFG_REQ.wdata[BDEC_FLAG_BIT])
         begin
            discard_expiry_flag_nxt = 1'b0;
         end
      end
      // a discard in the clearing cycle must not be lost, so set wins
      if (dt_expire)
      begin
         discard_expiry_flag_nxt = 1'b1;
      end
   end

   // read port; unmapped offsets answer zero
   always_comb
   begin
      rvalid_nxt = CFG_REQ.rd;
      rdata_nxt = rdata_r;
      if (CFG_REQ.rd)
      begin
         rdata_nxt = hit ? reg_view : 16'h0000;
      end
   end

   // message request: one outstanding, held until the link takes it
   always_comb
   begin
      msg_pend_nxt = msg_pend_r;
      msg_fatal_nxt = msg_fatal_r;
      if (msg_pend_r && ERR_MSG_READY)
      begin
         msg_pend_nxt = 1'b0;
      end
      if (send_msg)
      begin
         msg_pend_nxt = 1'b1;
         msg_fatal_nxt = AER_SUPPORTED && AER_DT_FATAL;
      end
   end

   // all state registers of the block
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         discard_error_msg_enable_r <= BDEC_BRCTL_RST[BDEC_MSGEN_BIT];
         discard_expiry_flag_r <= BDEC_BRCTL_RST[BDEC_FLAG_BIT];
         secondary_timeout_select_r <= BDEC_BRCTL_RST[BDEC_TSEL_BIT];
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
         msg_pend_r <= 1'b0;
         msg_fatal_r <= 1'b0;
      end
      else
      begin
         discard_error_msg_enable_r <= discard_error_msg_enable_nxt;
         discard_expiry_flag_r <= discard_expiry_flag_nxt;
         secondary_timeout_select_r <= secondary_timeout_select_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         msg_pend_r <= msg_pend_nxt;
         msg_fatal_r <= msg_fatal_nxt;
      end
   end

   assign CFG_RDATA = rdata_r;
   assign CFG_RVALID = rvalid_r;
   assign DT_DROP = dt_expire;
   assign ERR_MSG.valid = msg_pend_r;
   assign ERR_MSG.fatal = msg_fatal_r;

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);

   // a discard seen while no message is waiting
   sequence s_discard_idle;
      dt_expire && !msg_pend_r;
   endsequence

   // a discard with the enable honoured
   sequence s_discard_enabled;
      dt_expire && CONV_PCI_MODE && discard_error_msg_enable_r;
   endsequence

   a_reset_clears_all:
   assert property (@(posedge CLOCK) disable iff (1'b0)
      SRST |=> (reg_view == BDEC_BRCTL_RST) && !msg_pend_r)
   else $error("bridge control not zero after reset");

   a_rsvd_reads_zero:
   assert property ((CFG_REQ.rd && hit) |=> CFG_RVALID && (CFG_RDATA[15:12] == 4'h0))
   else $error("reserved bits read nonzero");

   a_enable_ignored_out:
   assert property ((s_discard_idle and (!CONV_PCI_MODE && !aer_path)) |=> !ERR_MSG.valid)
   else $error("message sent outside conventional mode");

   a_msg_when_enabled:
   assert property (s_discard_enabled |=> ERR_MSG.valid)
   else $error("enabled discard raised no message");

   a_fatal_needs_aer:
   assert property (ERR_MSG.valid |-> (!ERR_MSG.fatal || AER_SUPPORTED))
   else $error("fatal message without advanced reporting");

   a_msg_suppressed:
   assert property ((s_discard_idle and (!discard_error_msg_enable_r && !aer_path)) |=> !ERR_MSG.valid)
   else $error("disabled discard still raised a message");

   a_flag_on_drop:
   assert property (DT_DROP |=> discard_expiry_flag_r ##1 (discard_expiry_flag_r || $past(wr_upper)))
   else $error("discard flag not set by drop");

   a_flag_ignores_enable:
   assert property ((dt_expire && !discard_error_msg_enable_r) |=> discard_expiry_flag_r)
   else $error("discard flag depends on enable");

   a_msg_held_until_taken:
   assert property ((ERR_MSG.valid && !ERR_MSG_READY) |=> ERR_MSG.valid && ($stable(ERR_MSG.fatal) || $past(dt_expire)))
   else $error("message request dropped before acceptance");

endmodule // bdec_top

/* tb/bdec_link_model.sv */
// behavioural model of the upstream link port that takes error messages
`timescale 1ns/1ps
module bdec_link_model
   import bdec_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input bdec_pkg::bdec_msg_t msg,
   input wire logic [3:0] stall,
   output logic ready,
   output int rx_count,
   output logic rx_fatal
);
   int wait_r = 0;
   initial ready = 1'b0;
   initial rx_count = 0;
   initial rx_fatal = 1'b0;
   // ready only after the programmed stall, like a link short of credits
   always @(negedge clk)
   begin
      ready <= msg.valid && !srst && (wait_r >= int'(stall));
      wait_r <= msg.valid ? wait_r + 1 : 0;
   end
   // a message is taken at a rising edge with valid and ready both high
   always @(posedge clk)
   begin
      if (msg.valid && ready)
      begin
         rx_count <= rx_count + 1;
         rx_fatal <= msg.fatal;
      end
   end
endmodule // bdec_link_model

/* tb/bdec_top_tb_top.sv */
// self-checking bench for the bridge discard error control block
`timescale 1ns/1ps
module bdec_top_tb_top;
   import bdec_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   bdec_cfg_t cfg = '0;
   logic [15:0] rdata;
   logic rvalid, drop, busy, ready, rx_fatal;
   logic conv = 1'b1;
   logic at_head = 1'b0;
   logic retry = 1'b0;
   logic dt_mask = 1'b1;
   logic dt_fatal = 1'b0;
   logic [3:0] stall = 4'h0;
   bdec_msg_t msg;
   int rx_count;
   int err_total = 0;
   int comparisons = 0;

   // short timer lengths keep the run brief; expectations use the same values
   bdec_top #(.DT_LONG_CLKS(40), .DT_SHORT_CLKS(8), .AER_SUPPORTED(1'b1)) uut
   (
      .CLOCK(clock), .SRST(srst), .CFG_REQ(cfg), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
      .CONV_PCI_MODE(conv), .DC_AT_HEAD(at_head), .MASTER_RETRY(retry), .AER_DT_MASK(dt_mask),
      .AER_DT_FATAL(dt_fatal), .DT_DROP(drop), .DT_BUSY(busy), .ERR_MSG(msg), .ERR_MSG_READY(ready)
   );

   bdec_link_model link
   (
      .clk(clock), .srst(srst), .msg(msg), .stall(stall), .ready(ready),
      .rx_count(rx_count), .rx_fatal(rx_fatal)
   );

   initial
   begin
      forever #25 clock = ~clock;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read strobe for one cycle, answer looked at in the cycle after the strobe is sampled
   task automatic cfg_read(input logic [7:0] a, input logic [15:0] exp);
      @(negedge clock);
      cfg.rd = 1'b1;
      cfg.addr = a;
      @(negedge clock);
      cfg.rd = 1'b0;
      chk(16'(rvalid), 16'h0001);
      chk(rdata, exp);
   endtask

   task automatic cfg_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(negedge clock);
      cfg.wr = 1'b1;
      cfg.addr = a;
      cfg.be = be;
      cfg.wdata = d;
      @(negedge clock);
      cfg.wr = 1'b0;
   endtask

   // one timer run to expiry; drop must land exactly n cycles after the start
   task automatic discard(input int n, input logic send, input logic fat);
      int c0;
      c0 = rx_count;
      @(negedge clock) at_head = 1'b1;
      @(negedge clock) at_head = 1'b0;
      chk(16'(busy), 16'h0001);
      repeat (n - 1) @(negedge clock);
      chk(16'(drop), 16'h0000);
      @(negedge clock);
      chk(16'(drop), 16'h0001);
      repeat (12) @(negedge clock);
      chk(16'(rx_count - c0), 16'(send));
      if (send)
      begin
         chk(16'(rx_fatal), 16'(fat));
      end
   endtask

   task automatic print_verdict();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (5) @(negedge clock);
      srst = 1'b0;
      cfg_read(8'h3E, 16'h0000);
      cfg_read(8'h3C, 16'h0000);
      cfg_write(8'h3E, 2'h3, 16'hFFFF);
      cfg_read(8'h3E, 16'h0A00);
      cfg_write(8'h3E, 2'h1, 16'h0000);
      cfg_write(8'h3C, 2'h3, 16'h0000);
      cfg_read(8'h3E, 16'h0A00);
      discard(8, 1'b1, 1'b0);
      cfg_read(8'h3E, 16'h0E00);
      cfg_write(8'h3E, 2'h2, 16'h0C00);
      cfg_read(8'h3E, 16'h0800);
      // enable ignored outside conventional mode, slow link
      conv = 1'b0;
      stall = 4'h3;
      discard(40, 1'b0, 1'b0);
      cfg_read(8'h3E, 16'h0C00);
      dt_mask = 1'b0;
      dt_fatal = 1'b1;
      discard(40, 1'b1, 1'b1);
      conv = 1'b1;
      dt_mask = 1'b1;
      dt_fatal = 1'b0;
      cfg_write(8'h3E, 2'h2, 16'h0600);
      discard(8, 1'b0, 1'b0);
      cfg_read(8'h3E, 16'h0600);
      cfg_write(8'h3E, 2'h2, 16'h0600);
      // master repeats in time: no drop, no flag
      @(negedge clock) at_head = 1'b1;
      @(negedge clock) at_head = 1'b0;
      repeat (3) @(negedge clock);
      retry = 1'b1;
      @(negedge clock) retry = 1'b0;
      repeat (12) @(negedge clock);
      chk(16'(busy), 16'h0000);
      cfg_read(8'h3E, 16'h0200);
      chk(16'(rx_count), 16'h0002);
      print_verdict();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (3000) @(posedge clock);
      err_total++;
      print_verdict();
   end
endmodule // bdec_top_tb_top
